// >>> hdl/integrity_pkg.sv
// Constants, register map and types for the memory integrity monitor
// Overview of operation
// - Three states idle, listen, detect; idle after reset.
// - While idle, memories keep storing indications but do not report them.
// - In listen, a seen indication sets the status flag and raises the interrupt.
// - In detect, indication sits in info register, memory index in index register.
// - Separate status bits report idle, detect and listen.
// - Software steps states with a one-shot activate; transitions may take cycles.
// - Activate stays set until next state reached; busy high during transition.
// - First activate after reset clears all detection logic, goes idle to listen.
// - Each memory holds one indication, cleared once read through the monitor.
// - An indication is four flags plus one memory address.
// - Uncorrectable upset with room: set error flag, capture address.
// - Uncorrectable upset without room: set uncorrectable overflow flag.
// - Correctable upset with room: set correctable flag, capture address.
// - Correctable upset without room: set correctable overflow flag.
// - Uncorrectable information takes priority over correctable information.
// - Addresses are captured only in listen; otherwise only flags are set.
// - Upsets found on reads, both kinds, reportable through the interrupt.
// - Reset does not alter memory contents; only power cycle does.
// - Interrupt output feeds system interrupt source bit 21.
package integrity_pkg;
    // Register byte offsets
    localparam logic [4:0] off_control = 5'h00;
    localparam logic [4:0] off_status = 5'h04;
    localparam logic [4:0] off_info = 5'h08;
    localparam logic [4:0] off_index = 5'h0c;
    localparam logic [4:0] off_speed = 5'h10;
    // Control fields
    localparam int ctrl_activate_bit = 0;
    localparam int ctrl_pcie_bit = 1;
    // Status fields
    localparam int stat_idle_bit = 0;
    localparam int stat_detect_bit = 1;
    localparam int stat_listen_bit = 2;
    localparam int stat_busy_bit = 3;
    localparam int stat_indication_bit = 4;
    // Info fields: flags in 3:0, address from bit 8
    localparam int info_err_bit = 0;
    localparam int info_err_ovf_bit = 1;
    localparam int info_cor_bit = 2;
    localparam int info_cor_ovf_bit = 3;
    localparam int info_addr_lsb = 8;
    // Reset values
    localparam logic [15:0] speed_reset = 16'h00ff;
    // Interrupt source slot in the system controller
    localparam int integrity_irq_index = 21;
    // AXI responses
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    // Monitor states
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_listen = 3'b010,
        st_detect = 3'b100
    } mon_state_t;
endpackage

// >>> hdl/memory_integrity_monitor.sv
// Memory integrity monitor with AXI4-Lite register access
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module memory_integrity_monitor
    import integrity_pkg::*;
#(
    parameter int num_mems = 8,
    parameter int addr_width = 16,
    parameter int pcie_mems = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [num_mems-1:0] mem_read,
    input wire logic [num_mems-1:0] correctable_flag_upset,
    input wire logic [num_mems-1:0] mem_uncor_upset,
    input wire logic [num_mems*addr_width-1:0] mem_read_addr,
    output logic integrity_interrupt
);
    // Width of a memory index, never below one bit
    localparam int idx_w = (num_mems > 1) ? $clog2(num_mems) : 1;

    // Decode of a register byte address
    function automatic logic addr_is(input logic [4:0] a, input logic [4:0] off);
        return a[4:2] == off[4:2];
    endfunction

    // Register and state storage
    mon_state_t state_q, state_d;
    logic activate_q;
    logic pcie_mac_monitor_enable_q;
    logic [15:0] speed_q;
    logic [15:0] div_cnt_q;
    logic first_done_q;
    logic indication_q;
    logic [idx_w:0] scan_q;
    logic [3:0] info_flags_q;
    logic [addr_width-1:0] info_addr_q;
    logic [idx_w-1:0] info_idx_q;
    logic irq_q;
    // Per memory indication store, one indication each
    logic [num_mems-1:0] err_q; // Uncorrectable with address
    logic [num_mems-1:0] err_ovf_q; // Uncorrectable, address lost
    logic [num_mems-1:0] cor_q; // Correctable with address
    logic [num_mems-1:0] cor_ovf_q; // Correctable, address lost
    logic [addr_width-1:0] addr_q [num_mems];

    // Bus handshake storage
    logic aw_held_q, w_held_q;
    logic awready_q, wready_q; // Ready outputs straight from flops
    logic [4:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    // Divider tick paces monitor steps
    wire tick = (div_cnt_q == 16'h0000);

    // Memories allowed to report; PCIe MAC memories sit at the top indices
    logic [num_mems-1:0] mem_enabled;
    genvar g;
    generate
        for (g = 0; g < num_mems; g++) begin : gen_en
            assign mem_enabled[g] = (g < num_mems - pcie_mems) || pcie_mac_monitor_enable_q;
        end
    endgenerate

    // Pending indications of memories allowed to report
    wire [num_mems-1:0] has_ind = (err_q | err_ovf_q | cor_q | cor_ovf_q) & mem_enabled;
    wire any_ind = |has_ind;
    wire in_listen = (state_q == st_listen);
    wire in_detect = (state_q == st_detect);
    wire in_idle = (state_q == st_idle);
    // Report only while listening; idle and detect stay quiet
    wire report = in_listen && any_ind;
    wire scan_at_end = (scan_q >= (idx_w+1)'(num_mems));
    wire [idx_w-1:0] scan_idx = scan_q[idx_w-1:0];
    wire scan_hit = !scan_at_end && has_ind[scan_idx];

    // Write decode
    wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
    wire wr_ctrl = wr_fire && addr_is(awaddr_q, off_control);
    wire wr_speed = wr_fire && addr_is(awaddr_q, off_speed);
    wire wr_ok = addr_is(awaddr_q, off_control) || addr_is(awaddr_q, off_speed);
    // Activate request, one-shot set by software
    wire act_set = wr_ctrl && wstrb_q[0] && wdata_q[ctrl_activate_bit];

    // Step logic: a step happens on a divider tick while activate is pending
    wire step = activate_q && tick;
    // Leaving detect clears the indication that was read
    wire consume = step && in_detect;
    wire first_step = step && in_idle && !first_done_q;
    // Transition completes when the next state is reached
    logic step_done;
    always_comb begin
        state_d = state_q;
        step_done = 1'b0;
        case (state_q)
            st_idle: begin
                // A memory without an indication is passed in one step
                if (step) begin
                    if (!first_done_q || scan_at_end) begin
                        state_d = st_listen;
                        step_done = 1'b1;
                    end else if (scan_hit) begin
                        state_d = st_detect;
                        step_done = 1'b1;
                    end
                end
            end
            st_listen: begin
                if (step) begin
                    state_d = st_idle;
                    step_done = 1'b1;
                end
            end
            st_detect: begin
                // Activate stays pending so the scan goes on
                if (step) begin
                    state_d = st_idle;
                end
            end
            default: state_d = st_idle;
        endcase
    end

    // Monitor state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= st_idle;
        end else begin
            state_q <= state_d;
        end
    end

    // Activate stays pending until a state is reached
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            activate_q <= 1'b0;
        end else if (step_done) begin
            activate_q <= 1'b0;
        end else if (act_set) begin
            activate_q <= 1'b1;
        end
    end

    // Divider, scan pointer and first-activate tracking
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_q <= speed_reset;
            first_done_q <= 1'b0;
            scan_q <= '0;
        end else begin
            // Reload while nothing is pending, so a first step waits a full period
            div_cnt_q <= (tick || !activate_q) ? speed_q : div_cnt_q - 16'h0001;
            if (first_step) begin
                first_done_q <= 1'b1;
            end
            if (state_q == st_listen && state_d == st_idle) begin
                scan_q <= '0;
            end else if (step && in_idle && first_done_q && !scan_at_end) begin
                scan_q <= scan_q + (idx_w+1)'(1);
            end
        end
    end

    // Presented indication for the detect state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            info_flags_q <= 4'h0;
            info_addr_q <= '0;
            info_idx_q <= '0;
        end else if (step && in_idle && scan_hit && first_done_q) begin
            // Loaded on the step that stops in detect
            info_flags_q <= {cor_ovf_q[scan_idx], cor_q[scan_idx],
                             err_ovf_q[scan_idx], err_q[scan_idx]};
            info_addr_q <= addr_q[scan_idx];
            info_idx_q <= scan_idx;
        end
    end

    // Per memory detection logic
    generate
        for (g = 0; g < num_mems; g++) begin : gen_mem
            // Upsets count only with a read strobe
            wire unc = mem_read[g] && mem_uncor_upset[g];
            wire cor = mem_read[g] && correctable_flag_upset[g] && !mem_uncor_upset[g];
            wire room = in_listen && !err_q[g] && !cor_q[g];
            wire room_unc = in_listen && !err_q[g];
            wire cor_info = cor_q[g] || cor_ovf_q[g];
            wire clr = (consume && info_idx_q == idx_w'(g)) || first_step;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    err_q[g] <= 1'b0;
                    err_ovf_q[g] <= 1'b0;
                    cor_q[g] <= 1'b0;
                    cor_ovf_q[g] <= 1'b0;
                    // Only this copy is reset; the memory arrays keep their contents
                    addr_q[g] <= '0;
                end else begin
                    // Upset flags win over a same-cycle clear
                    if (unc && room_unc) begin
                        err_q[g] <= 1'b1;
                        cor_q[g] <= 1'b0;
                        cor_ovf_q[g] <= cor_info; // Correctable address given up
                        addr_q[g] <= mem_read_addr[g*addr_width +: addr_width];
                    end else if (clr) begin
                        err_q[g] <= 1'b0;
                        cor_q[g] <= 1'b0;
                        cor_ovf_q[g] <= cor && !room;
                    end else if (cor && room) begin
                        cor_q[g] <= 1'b1;
                        addr_q[g] <= mem_read_addr[g*addr_width +: addr_width];
                    end else if (cor) begin
                        cor_ovf_q[g] <= 1'b1;
                    end
                    if (unc && !room_unc) begin
                        err_ovf_q[g] <= 1'b1;
                    end else if (clr) begin
                        err_ovf_q[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Indication status and interrupt
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            indication_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            indication_q <= report;
            irq_q <= report;
        end
    end

    // Software-written configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            speed_q <= speed_reset;
            pcie_mac_monitor_enable_q <= 1'b0;
        end else begin
            // Divider takes byte lanes 0 and 1
            if (wr_speed) begin
                if (wstrb_q[0]) speed_q[7:0] <= wdata_q[7:0];
                if (wstrb_q[1]) speed_q[15:8] <= wdata_q[15:8];
            end
            if (wr_ctrl && wstrb_q[0]) begin
                pcie_mac_monitor_enable_q <= wdata_q[ctrl_pcie_bit];
            end
        end
    end

    // Write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            awaddr_q <= 5'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= resp_okay;
        end else begin
            if (s_axi_awvalid && !aw_held_q) begin
                aw_held_q <= 1'b1;
                awready_q <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_q) begin
                w_held_q <= 1'b1;
                wready_q <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            // Response stands until the master takes it
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? resp_okay : resp_slverr;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // Read data selection
    wire [31:0] stat_word = 32'({
        indication_q,
        activate_q,
        in_listen,
        in_detect,
        in_idle});
    wire [31:0] info_word = 32'({
        info_addr_q,
        4'h0,
        info_flags_q});
    logic [31:0] rd_word;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        if (addr_is(s_axi_araddr, off_control)) begin
            rd_word = 32'({pcie_mac_monitor_enable_q, activate_q});
        end else if (addr_is(s_axi_araddr, off_status)) begin
            rd_word = stat_word;
        end else if (addr_is(s_axi_araddr, off_info)) begin
            rd_word = info_word;
        end else if (addr_is(s_axi_araddr, off_index)) begin
            rd_word = 32'(info_idx_q);
        end else if (addr_is(s_axi_araddr, off_speed)) begin
            rd_word = 32'(speed_q);
        end else begin
            rd_word = 32'h0000_0000;
            rd_ok = 1'b0;
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= resp_okay;
        end else begin
            arready_q <= 1'b0;
            // One read at a time: no accept while an answer stands
            if (s_axi_arvalid && !arready_q && !rvalid_q) begin
                arready_q <= 1'b1;
                rvalid_q <= 1'b1;
                rdata_q <= rd_word;
                rresp_q <= rd_ok ? resp_okay : resp_slverr;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign integrity_interrupt = irq_q;
endmodule // memory_integrity_monitor
`default_nettype wire

// >>> tb/mim_sva.sv
// Bus and interrupt assertions for the memory integrity monitor
`timescale 1ns/10ps
`default_nettype none
module mim_sva #(
    parameter int num_mems = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [num_mems-1:0] mem_read,
    input wire logic [num_mems-1:0] correctable_flag_upset,
    input wire logic [num_mems-1:0] mem_uncor_upset,
    input wire logic integrity_interrupt
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Write steps: both halves taken, then response accepted
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_b_done;
        s_axi_bvalid && s_axi_bready;
    endsequence
    property p_reset;
        disable iff (1'b0) !aresetn |=> s_axi_awready && s_axi_wready && !s_axi_bvalid
            && !s_axi_rvalid && !integrity_interrupt;
    endproperty
    property p_wr_resp;
        s_wr_take |=> ##1 s_axi_bvalid;
    endproperty
    property p_wr_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    property p_b_release;
        s_b_done |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_rd_answer;
        s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_rvalid && s_axi_arready;
    endproperty
    property p_ar_pair;
        s_axi_arready |-> s_axi_rvalid;
    endproperty
    property p_irq_cause;
        $rose(integrity_interrupt) |-> $past(|(mem_read & (correctable_flag_upset | mem_uncor_upset)), 2);
    endproperty
    a_reset: assert property (p_reset) else $error("bus or interrupt not quiet after reset");
    a_wr_resp: assert property (p_wr_resp) else $error("write response late");
    a_wr_block: assert property (p_wr_block) else $error("write accepted during response");
    a_b_release: assert property (p_b_release) else $error("write channel not freed");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    a_ar_pair: assert property (p_ar_pair) else $error("read accept without data");
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without upset");
endmodule // mim_sva
bind memory_integrity_monitor mim_sva #(.num_mems(num_mems)) chk_i (.*);
`default_nettype wire

// >>> tb/mem_model.sv
// Behavioural model of the protected memories reporting reads and upsets
`timescale 1ns/10ps
`default_nettype none
module mem_model #(
    parameter int n = 8,
    parameter int aw = 16
) (
    input wire logic aclk,
    output logic [n-1:0] rd,
    output logic [n-1:0] cor,
    output logic [n-1:0] unc,
    output logic [n*aw-1:0] addr
);
    // Quiet lines at time zero
    initial begin
        rd = '0;
        cor = '0;
        unc = '0;
        addr = '0;
    end
    // One read on memory g: kind 0 clean, 1 correctable, 2 uncorrectable
    task automatic hit(input int g, input int kind, input logic [aw-1:0] a);
        begin
            @(posedge aclk);
            rd[g] <= 1'b1;
            cor[g] <= (kind == 1);
            unc[g] <= (kind == 2);
            addr[g*aw +: aw] <= a;
            @(posedge aclk);
            rd <= '0;
            cor <= '0;
            unc <= '0;
            addr <= ~addr; // Address not held after the read
        end
    endtask
endmodule // mem_model
`default_nettype wire

// >>> tb/memory_integrity_monitor_tb_top.sv
// Register-level testbench for the memory integrity monitor
`timescale 1ns/10ps
`default_nettype none
module memory_integrity_monitor_tb_top import integrity_pkg::*;;
    localparam int nm = 8;
    localparam int aw = 16;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [nm-1:0] mrd, mcor, munc;
    logic [nm*aw-1:0] maddr;
    int n_errors = 0;
    int checked = 0;
    // 250 MHz clock
    always #2 aclk = ~aclk;
    memory_integrity_monitor #(.num_mems(nm), .addr_width(aw), .pcie_mems(2)) uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .mem_read(mrd), .correctable_flag_upset(mcor), .mem_uncor_upset(munc),
        .mem_read_addr(maddr), .integrity_interrupt(irq));
    mem_model #(.n(nm), .aw(aw)) mm (.aclk(aclk), .rd(mrd), .cor(mcor), .unc(munc), .addr(maddr));
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            checked++;
            if (got !== exp) begin
                n_errors++;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // Counts, verdict, end of run
    task automatic tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", checked, n_errors);
            if (n_errors == 0 && checked > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // Bus write, address and data offered together
    task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] er);
        int n;
        begin
            n = 0;
            @(posedge aclk);
            awaddr <= a;
            wdata <= v;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do begin
                @(posedge aclk);
                n++;
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (!bvalid && n < 60);
            chk({31'h0, bvalid}, 32'h1);
            bready <= 1'b0;
            chk({30'h0, bresp}, {30'h0, er});
        end
    endtask
    // Bus read into d and r
    task automatic rd(input logic [4:0] a);
        int n;
        begin
            n = 0;
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do begin
                @(posedge aclk);
                n++;
                if (arready) arvalid <= 1'b0;
            end while (!rvalid && n < 60);
            chk({31'h0, rvalid}, 32'h1);
            d = rdata;
            r = rresp;
            rready <= 1'b0;
        end
    endtask
    // Read and compare data and response
    task automatic rc(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] er);
        begin
            rd(a);
            chk(d, exp);
            chk({30'h0, r}, {30'h0, er});
        end
    endtask
    // Wait for activate to drop, then compare state and busy bits
    task automatic settle(input logic [31:0] st);
        int n;
        begin
            n = 0;
            do begin
                rd(off_control);
                n++;
            end while (d[ctrl_activate_bit] === 1'b1 && n < 100);
            chk({31'h0, d[ctrl_activate_bit]}, 32'h0);
            rd(off_status);
            chk(d & 32'hf, st);
        end
    endtask
    // One requested step
    task automatic step(input logic [31:0] st);
        begin
            wr(off_control, 32'h1, resp_okay);
            settle(st);
        end
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rc(off_status, 32'h1, resp_okay);
        rc(off_speed, 32'h00ff, resp_okay);
        rc(off_control, 32'h0, resp_okay);
        rc(5'h14, 32'h0, resp_slverr);
        wr(off_status, 32'h1, resp_slverr);
        $display("test reset and map done");
        mm.hit(1, 2, 16'h0042);
        wr(off_speed, 32'h20, resp_okay);
        wr(off_control, 32'h1, resp_okay);
        rd(off_status);
        chk(d & 32'hf, 32'h9);
        rc(off_control, 32'h1, resp_okay);
        settle(32'h4);
        chk({31'h0, irq}, 32'h0);
        wr(off_speed, 32'h0, resp_okay);
        $display("test first activate done");
        mm.hit(0, 1, 16'h0011);
        mm.hit(0, 2, 16'h0022);
        mm.hit(0, 2, 16'h0033);
        mm.hit(5, 1, 16'h0abc);
        mm.hit(5, 1, 16'h0def);
        mm.hit(6, 0, 16'h0077);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        rd(off_status);
        chk(d & 32'h1f, 32'h14);
        $display("test listen done");
        step(32'h1);
        mm.hit(3, 2, 16'h0055);
        step(32'h2);
        rc(off_info, 32'h0000220b, resp_okay);
        rc(off_index, 32'h0, resp_okay);
        step(32'h2);
        rd(off_info);
        chk(d & 32'hff, 32'h2);
        rc(off_index, 32'h3, resp_okay);
        step(32'h2);
        rc(off_info, 32'h000abc0c, resp_okay);
        rc(off_index, 32'h5, resp_okay);
        chk({31'h0, (d < 32'(nm))}, 32'h1);
        step(32'h4);
        chk({31'h0, irq}, 32'h0);
        step(32'h1);
        step(32'h4);
        $display("test readout done");
        mm.hit(7, 2, 16'h0066);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        $display("test gated memory done");
        tally_and_finish;
    end
    // Watchdog against a hung handshake
    initial begin
        #100000;
        n_errors++;
        tally_and_finish;
    end
endmodule // memory_integrity_monitor_tb_top
`default_nettype wire
